// ==== core/fcef_defs.svh ====
// Offsets, field positions and reset values of the flash config slice
`ifndef FCEF_DEFS_SVH
`define FCEF_DEFS_SVH

// ==========================================================
// Register offsets
`define FCEF_OFS_INDEX 8'h02
`define FCEF_OFS_RSV 8'h03
`define FCEF_OFS_CFG 8'h04
`define FCEF_OFS_ERRCFG 8'h05
`define FCEF_OFS_STAT 8'h06
`define FCEF_OFS_ERRSTAT 8'h07
`define FCEF_OFS_IRQSTAT 8'h08
`define FCEF_OFS_IRQMASK 8'h09

// ==========================================================
// Field positions
`define FCEF_CFG_COMPLETION_IRQ_ENABLE 7
`define FCEF_CFG_SINGLE_FAULT_IGNORE 4
`define FCEF_CFG_DFFORCE 1
`define FCEF_CFG_SFFORCE 0
`define FCEF_ERRCFG_DFIE 1
`define FCEF_ERRCFG_SFIE 0
`define FCEF_STAT_CCF 7
`define FCEF_ERR_DF 1
`define FCEF_ERR_SF 0
`define FCEF_IRQ_CC 0
`define FCEF_IRQ_SF 1
`define FCEF_IRQ_DF 2

// ==========================================================
// Reset values and masks
`define FCEF_INDEX_RST 3'h0
`define FCEF_CFG_WMASK 8'h93
`define FCEF_IRQMASK_RST 3'h7
`define FCEF_RDATA_ZERO 8'h00

`endif

// ==== core/fcef_pkg.sv ====
// Types shared by the flash config slice and its users
`default_nettype none
package fcef_pkg;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fcef_bus_req_t;

  // One CPU array read with its genuine ECC result
  typedef struct packed {
    logic read;
    logic sglFault;
    logic dblFault;
  } fcef_arr_rd_t;

  // Whole state of the register slice
  typedef struct packed {
    logic [2:0] wordSel;
    logic completion_irq_enable;
    logic single_fault_ignore;
    logic dfForce;
    logic sfForce;
    logic dfIrqEn;
    logic sfIrqEn;
    logic ccFlag;
    logic sfFlag;
    logic dfFlag;
    logic [2:0] irqMask;
    logic [7:0] rdata;
    logic irq;
    logic cmdLaunch;
    logic eccCapture;
  } fcef_state_t;

endpackage : fcef_pkg
`default_nettype wire

// ==== core/fcef_regs.sv ====
// Index, reserved and fault-inject configuration registers of a flash
//
// Contract
// (RULE1) Index field selects command parameter word
// (RULE2) Index resets zero, upper bits read zero
// (RULE3) Reserved test register reads zero, ignores writes
// (RULE4) Config: only four bits writable, rest zero
// (RULE5) Completion enable requests interrupt on complete
// (RULE6) Ignore control suppresses single fault reporting
// (RULE7) Double force sets double flag each read
// (RULE8) Otherwise double flag only on real fault
// (RULE9) Forced double leaves capture unless genuine
// (RULE10) Single force sets single flag each read
// (RULE11) Otherwise single flag only on real fault
// (RULE12) Forced single leaves capture unless genuine
// (RULE13) Force controls persist until software clears
// (RULE14) Forcing applies to CPU array reads
// (RULE15) Complete flag high idle, write one launches
// (RULE16) Double fault interrupt enable at bit one
// (RULE17) Single fault interrupt enable at bit zero
// (RULE18) Config bits reset to zero
`include "fcef_defs.svh"
`default_nettype none

module fcef_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire fcef_pkg::fcef_bus_req_t busReq,
  output logic [7:0] rdata,
  input wire fcef_pkg::fcef_arr_rd_t arrRead,
  input wire logic cmdDone,
  output logic cmdLaunch,
  output logic [2:0] wordSel,
  output logic eccCapture,
  output logic irq
);
  import fcef_pkg::*;

  // ==========================================================
  // Elaboration check
  generate
    if (ADDR_W != 8) begin : g_bad_addr
      $error("fcef_regs: ADDR_W must be 8");
    end
  endgenerate

  fcef_state_t s_q;
  fcef_state_t s_d;
  logic sfEvt;
  logic dfEvt;
  logic [2:0] pend;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.rdata = `FCEF_RDATA_ZERO;
    s_d.cmdLaunch = 1'b0;

    // Read decode on the current state; data shows one cycle later
    if (busReq.rd) begin
      if (busReq.addr == `FCEF_OFS_INDEX) begin
        s_d.rdata = {5'h00, s_q.wordSel}; // RULE2
      end else if (busReq.addr == `FCEF_OFS_RSV) begin
        s_d.rdata = `FCEF_RDATA_ZERO; // RULE3
      end else if (busReq.addr == `FCEF_OFS_CFG) begin
        s_d.rdata[`FCEF_CFG_COMPLETION_IRQ_ENABLE] = s_q.completion_irq_enable; // RULE4
        s_d.rdata[`FCEF_CFG_SINGLE_FAULT_IGNORE] = s_q.single_fault_ignore;
        s_d.rdata[`FCEF_CFG_DFFORCE] = s_q.dfForce;
        s_d.rdata[`FCEF_CFG_SFFORCE] = s_q.sfForce;
      end else if (busReq.addr == `FCEF_OFS_ERRCFG) begin
        s_d.rdata[`FCEF_ERRCFG_DFIE] = s_q.dfIrqEn;
        s_d.rdata[`FCEF_ERRCFG_SFIE] = s_q.sfIrqEn;
      end else if (busReq.addr == `FCEF_OFS_STAT) begin
        s_d.rdata[`FCEF_STAT_CCF] = s_q.ccFlag;
      end else if (busReq.addr == `FCEF_OFS_ERRSTAT) begin
        s_d.rdata[`FCEF_ERR_DF] = s_q.dfFlag;
        s_d.rdata[`FCEF_ERR_SF] = s_q.sfFlag;
      end else if (busReq.addr == `FCEF_OFS_IRQSTAT) begin
        s_d.rdata[`FCEF_IRQ_CC] = s_q.ccFlag;
        s_d.rdata[`FCEF_IRQ_SF] = s_q.sfFlag;
        s_d.rdata[`FCEF_IRQ_DF] = s_q.dfFlag;
      end else if (busReq.addr == `FCEF_OFS_IRQMASK) begin
        s_d.rdata = {5'h00, s_q.irqMask};
      end
    end

    // Writes; reserved register and unmapped offsets fall through
    if (busReq.wr) begin
      if (busReq.addr == `FCEF_OFS_INDEX) begin
        s_d.wordSel = busReq.wdata[2:0]; // RULE1
      end else if (busReq.addr == `FCEF_OFS_CFG) begin
        s_d.completion_irq_enable = busReq.wdata[`FCEF_CFG_COMPLETION_IRQ_ENABLE]; // RULE4
        s_d.single_fault_ignore = busReq.wdata[`FCEF_CFG_SINGLE_FAULT_IGNORE];
        s_d.dfForce = busReq.wdata[`FCEF_CFG_DFFORCE]; // RULE13
        s_d.sfForce = busReq.wdata[`FCEF_CFG_SFFORCE]; // RULE13
      end else if (busReq.addr == `FCEF_OFS_ERRCFG) begin
        s_d.dfIrqEn = busReq.wdata[`FCEF_ERRCFG_DFIE]; // RULE16
        s_d.sfIrqEn = busReq.wdata[`FCEF_ERRCFG_SFIE]; // RULE17
      end else if (busReq.addr == `FCEF_OFS_STAT) begin
        // Launch only from idle; a second launch while busy is dropped
        if (busReq.wdata[`FCEF_STAT_CCF] && s_q.ccFlag) begin
          s_d.ccFlag = 1'b0; // RULE15
          s_d.cmdLaunch = 1'b1;
        end
      end else if (busReq.addr == `FCEF_OFS_ERRSTAT) begin
        if (busReq.wdata[`FCEF_ERR_DF]) begin
          s_d.dfFlag = 1'b0;
        end
        if (busReq.wdata[`FCEF_ERR_SF]) begin
          s_d.sfFlag = 1'b0;
        end
      end else if (busReq.addr == `FCEF_OFS_IRQSTAT) begin
        if (busReq.wdata[`FCEF_IRQ_DF]) begin
          s_d.dfFlag = 1'b0;
        end
        if (busReq.wdata[`FCEF_IRQ_SF]) begin
          s_d.sfFlag = 1'b0;
        end
      end else if (busReq.addr == `FCEF_OFS_IRQMASK) begin
        s_d.irqMask = busReq.wdata[2:0];
      end
    end

    // Completion from the command engine
    if (cmdDone && !s_q.ccFlag) begin
      s_d.ccFlag = 1'b1; // RULE15
    end

    // Fault events after the clears, so a set never gets lost
    sfEvt = arrRead.read && !s_q.single_fault_ignore &&
            (s_q.sfForce || arrRead.sglFault); // RULE6 RULE10 RULE11
    dfEvt = arrRead.read &&
            (s_q.dfForce || arrRead.dblFault); // RULE7 RULE8 RULE14
    if (sfEvt) begin
      s_d.sfFlag = 1'b1;
    end
    if (dfEvt) begin
      s_d.dfFlag = 1'b1;
    end

    // Capture follows only genuine faults, never a forced one
    s_d.eccCapture = arrRead.read && (arrRead.dblFault ||
                     (arrRead.sglFault && !s_q.single_fault_ignore)); // RULE9 RULE12

    // Interrupt uses next flags so it rises with the flag itself
    pend[0] = s_d.completion_irq_enable && s_d.ccFlag; // RULE5
    pend[1] = s_d.sfIrqEn && s_d.sfFlag; // RULE17
    pend[2] = s_d.dfIrqEn && s_d.dfFlag; // RULE16
    s_d.irq = |(pend & s_d.irqMask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0; // RULE18
      s_q.wordSel <= `FCEF_INDEX_RST; // RULE2
      s_q.ccFlag <= 1'b1;
      s_q.irqMask <= `FCEF_IRQMASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign cmdLaunch = s_q.cmdLaunch;
  assign wordSel = s_q.wordSel;
  assign eccCapture = s_q.eccCapture;
  assign irq = s_q.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  property p_idx_write;
    busReq.wr && busReq.addr == `FCEF_OFS_INDEX
      |=> wordSel == $past(busReq.wdata[2:0]);
  endproperty
  a_idx_write: assert property (p_idx_write) // RULE1
    else $error("index write not seen on word select");

  property p_idx_read;
    busReq.rd && busReq.addr == `FCEF_OFS_INDEX
      |=> rdata == {5'h00, $past(wordSel)};
  endproperty
  a_idx_read: assert property (p_idx_read) // RULE2
    else $error("index read data wrong");

  property p_rsv_zero;
    busReq.rd && busReq.addr == `FCEF_OFS_RSV |=> rdata == 8'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // RULE3
    else $error("reserved register read nonzero");

  property p_cfg_bits;
    busReq.rd && busReq.addr == `FCEF_OFS_CFG
      |=> (rdata & ~`FCEF_CFG_WMASK) == 8'h00;
  endproperty
  a_cfg_bits: assert property (p_cfg_bits) // RULE4
    else $error("unimplemented config bit read one");

  property p_cc_irq;
    s_q.completion_irq_enable && s_q.ccFlag && s_q.irqMask[0] |-> irq;
  endproperty
  a_cc_irq: assert property (p_cc_irq) // RULE5
    else $error("completion interrupt missing");

  property p_ign_sf;
    $rose(s_q.sfFlag) |-> !$past(s_q.single_fault_ignore);
  endproperty
  a_ign_sf: assert property (p_ign_sf) // RULE6
    else $error("single fault reported while ignored");

  property p_df_force;
    arrRead.read && s_q.dfForce |=> s_q.dfFlag;
  endproperty
  a_df_force: assert property (p_df_force) // RULE7
    else $error("forced double fault flag not set");

  property p_df_only;
    $rose(s_q.dfFlag)
      |-> $past(arrRead.read && (s_q.dfForce || arrRead.dblFault));
  endproperty
  a_df_only: assert property (p_df_only) // RULE8
    else $error("double fault flag set without cause");

  property p_capture;
    eccCapture |-> $past(arrRead.read &&
                         (arrRead.dblFault || arrRead.sglFault));
  endproperty
  a_capture: assert property (p_capture) // RULE9
    else $error("capture updated without genuine fault");

  property p_sf_force;
    arrRead.read && s_q.sfForce && !s_q.single_fault_ignore |=> s_q.sfFlag;
  endproperty
  a_sf_force: assert property (p_sf_force) // RULE10
    else $error("forced single fault flag not set");

  property p_force_hold;
    s_q.dfForce && !(busReq.wr && busReq.addr == `FCEF_OFS_CFG)
      |=> s_q.dfForce;
  endproperty
  a_force_hold: assert property (p_force_hold) // RULE13
    else $error("force control cleared itself");

  property p_launch;
    busReq.wr && busReq.addr == `FCEF_OFS_STAT &&
      busReq.wdata[`FCEF_STAT_CCF] && s_q.ccFlag
      |=> !s_q.ccFlag && cmdLaunch ##1 !cmdLaunch;
  endproperty
  a_launch: assert property (p_launch) // RULE15
    else $error("launch did not clear completion flag");

  property p_df_irq;
    s_q.dfIrqEn && s_q.dfFlag && s_q.irqMask[2] |-> irq;
  endproperty
  a_df_irq: assert property (p_df_irq) // RULE16
    else $error("double fault interrupt missing");

  property p_rst_cfg;
    @(posedge ref_clk) disable iff (1'b0)
      srst |=> !s_q.completion_irq_enable && !s_q.single_fault_ignore && !s_q.dfForce && !s_q.sfForce;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) // RULE18
    else $error("config not zero after reset");

  property p_idx_hold;
    !(busReq.wr && busReq.addr == `FCEF_OFS_INDEX) |=> $stable(wordSel);
  endproperty
  a_idx_hold: assert property (p_idx_hold) // RULE1
    else $error("word select moved without index write");

  property p_idx_rst;
    @(posedge ref_clk) disable iff (1'b0)
      srst |=> wordSel == 3'h0 && rdata == 8'h00 && !irq;
  endproperty
  a_idx_rst: assert property (p_idx_rst) // RULE2
    else $error("outputs not cleared by reset");

  property p_rsv_write;
    busReq.wr && busReq.addr == `FCEF_OFS_RSV |=>
      $stable({s_q.wordSel, s_q.completion_irq_enable, s_q.single_fault_ignore, s_q.dfForce,
               s_q.sfForce, s_q.dfIrqEn, s_q.sfIrqEn, s_q.irqMask});
  endproperty
  a_rsv_write: assert property (p_rsv_write) // RULE3
    else $error("reserved write changed a register");

  property p_cfg_read;
    busReq.rd && busReq.addr == `FCEF_OFS_CFG |=> rdata ==
      {$past(s_q.completion_irq_enable), 2'b00, $past(s_q.single_fault_ignore), 2'b00,
       $past(s_q.dfForce), $past(s_q.sfForce)};
  endproperty
  a_cfg_read: assert property (p_cfg_read) // RULE4
    else $error("config read data wrong");

  property p_cfg_write;
    busReq.wr && busReq.addr == `FCEF_OFS_CFG |=>
      s_q.completion_irq_enable == $past(busReq.wdata[`FCEF_CFG_COMPLETION_IRQ_ENABLE]) &&
      s_q.single_fault_ignore == $past(busReq.wdata[`FCEF_CFG_SINGLE_FAULT_IGNORE]) &&
      s_q.dfForce == $past(busReq.wdata[`FCEF_CFG_DFFORCE]) &&
      s_q.sfForce == $past(busReq.wdata[`FCEF_CFG_SFFORCE]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) // RULE4
    else $error("config write not taken");

  property p_irq_src;
    irq |-> (s_q.completion_irq_enable && s_q.ccFlag && s_q.irqMask[0]) ||
      (s_q.sfIrqEn && s_q.sfFlag && s_q.irqMask[1]) ||
      (s_q.dfIrqEn && s_q.dfFlag && s_q.irqMask[2]);
  endproperty
  a_irq_src: assert property (p_irq_src) // RULE5
    else $error("interrupt without enabled source");

  property p_sf_report;
    arrRead.read && arrRead.sglFault && !s_q.single_fault_ignore |=> s_q.sfFlag;
  endproperty
  a_sf_report: assert property (p_sf_report) // RULE6
    else $error("genuine single fault not reported");

  property p_df_cap;
    arrRead.read && arrRead.dblFault |=> eccCapture;
  endproperty
  a_df_cap: assert property (p_df_cap) // RULE9
    else $error("genuine double fault not captured");

  property p_sf_only;
    $rose(s_q.sfFlag)
      |-> $past(arrRead.read && (s_q.sfForce || arrRead.sglFault));
  endproperty
  a_sf_only: assert property (p_sf_only) // RULE11
    else $error("single fault flag set without cause");

  property p_cap_forced;
    arrRead.read && !arrRead.sglFault && !arrRead.dblFault
      |=> !eccCapture;
  endproperty
  a_cap_forced: assert property (p_cap_forced) // RULE12
    else $error("capture updated on a forced fault");

  property p_sf_hold;
    s_q.sfForce && !(busReq.wr && busReq.addr == `FCEF_OFS_CFG)
      |=> s_q.sfForce;
  endproperty
  a_sf_hold: assert property (p_sf_hold) // RULE13
    else $error("single force control cleared itself");

  property p_launch_busy;
    busReq.wr && busReq.addr == `FCEF_OFS_STAT && !s_q.ccFlag
      |=> !cmdLaunch;
  endproperty
  a_launch_busy: assert property (p_launch_busy) // RULE15
    else $error("launch accepted while busy");

  property p_cc_done;
    cmdDone && !s_q.ccFlag |=> s_q.ccFlag;
  endproperty
  a_cc_done: assert property (p_cc_done) // RULE15
    else $error("completion flag not set on done");

  property p_sf_irq;
    s_q.sfIrqEn && s_q.sfFlag && s_q.irqMask[1] |-> irq;
  endproperty
  a_sf_irq: assert property (p_sf_irq) // RULE17
    else $error("single fault interrupt missing");

  c_forced_df: cover property (arrRead.read && s_q.dfForce ##1 irq);
  c_forced_sf: cover property (arrRead.read && s_q.sfForce ##1 s_q.sfFlag);
  c_cmd_cycle: cover property (cmdLaunch ##[1:20] s_q.ccFlag);
  c_set_clear: cover property (busReq.wr &&
    busReq.addr == `FCEF_OFS_ERRSTAT && sfEvt);
  c_busy_refused: cover property (busReq.wr &&
    busReq.addr == `FCEF_OFS_STAT && !s_q.ccFlag);

endmodule // fcef_regs
`default_nettype wire

// ==== testbench/fcef_cmd_engine.sv ====
// Command engine model answering each launch with one completion pulse
`default_nettype none

module fcef_cmd_engine #(
  parameter int DELAY = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmdLaunch,
  output logic cmdDone
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // A slow engine, so the busy window is seen from the bus
  always @(posedge ref_clk) begin
    if (srst) begin
      cnt <= 0;
      cmdDone <= 1'b0;
    end else if (cmdLaunch) begin
      cnt <= DELAY;
      cmdDone <= 1'b0;
    end else begin
      cnt <= (cnt > 0) ? cnt - 1 : 0;
      cmdDone <= (cnt == 1);
    end
  end
endmodule // fcef_cmd_engine
`default_nettype wire

// ==== testbench/test_flash_cmd_index_and_ecc_fault_config.sv ====
// Self-checking bench of the flash index and fault-inject registers
`default_nettype none
`include "fcef_defs.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nFail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end

module test_flash_cmd_index_and_ecc_fault_config import fcef_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 8;
  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } fcef_row_t;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  fcef_bus_req_t busReq = '0;
  fcef_arr_rd_t arrRead = '0;
  logic [7:0] rdata;
  logic cmdDone;
  logic cmdLaunch;
  logic eccCapture;
  logic irq;
  logic [2:0] wordSel;
  int nFail = 0;
  int nTests = 0;
  fcef_row_t rows[9] = '{'{8'h02, 8'hff, 8'h07}, '{8'h03, 8'hff, 8'h00},
    '{8'h04, 8'hff, 8'h93}, '{8'h04, 8'h00, 8'h00},
    '{8'h05, 8'hff, 8'h03}, '{8'h09, 8'hff, 8'h07},
    '{8'h0a, 8'hff, 8'h00}, '{8'h08, 8'hff, 8'h01},
    '{8'h02, 8'h05, 8'h05}};

  always #5 ref_clk = ~ref_clk;

  fcef_regs fcef_regs_i (.ref_clk(ref_clk), .srst(srst), .busReq(busReq),
    .rdata(rdata), .arrRead(arrRead), .cmdDone(cmdDone),
    .cmdLaunch(cmdLaunch), .wordSel(wordSel), .eccCapture(eccCapture),
    .irq(irq));
  fcef_cmd_engine #(.DELAY(DLY)) fcef_cmd_engine_i (.ref_clk(ref_clk),
    .srst(srst), .cmdLaunch(cmdLaunch), .cmdDone(cmdDone));

  // ==========================================================
  // Bus and array tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq.rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask

  task automatic arr(input logic s, input logic d, input logic cap);
    @(posedge ref_clk);
    arrRead <= '{read: 1'b1, sglFault: s, dblFault: d};
    @(posedge ref_clk);
    arrRead <= '0;
    #1;
    `CHK("eccCapture", cap, eccCapture)
  endtask

  // Both status layers; either one alone clears the same single and double fault flags
  task automatic clr();
    wr(`FCEF_OFS_ERRSTAT, 8'h03);
    wr(`FCEF_OFS_IRQSTAT, 8'h06);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("irq", e, irq)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    rd(`FCEF_OFS_INDEX, 8'h00);
    rd(`FCEF_OFS_CFG, 8'h00);
    rd(`FCEF_OFS_STAT, 8'h80);
    irq_is(1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    `CHK("wordSel", 3'h5, wordSel)
    $display("test table done");
    wr(`FCEF_OFS_CFG, 8'h02);
    arr(1'b0, 1'b0, 1'b0);
    rd(`FCEF_OFS_ERRSTAT, 8'h02);
    irq_is(1'b1);
    wr(`FCEF_OFS_IRQMASK, 8'h00);
    irq_is(1'b0);
    wr(`FCEF_OFS_IRQMASK, 8'h07);
    clr();
    rd(`FCEF_OFS_CFG, 8'h02);
    arr(1'b0, 1'b0, 1'b0);
    rd(`FCEF_OFS_ERRSTAT, 8'h02);
    clr();
    irq_is(1'b0);
    wr(`FCEF_OFS_CFG, 8'h11);
    arr(1'b1, 1'b0, 1'b0);
    rd(`FCEF_OFS_ERRSTAT, 8'h00);
    irq_is(1'b0);
    wr(`FCEF_OFS_CFG, 8'h01);
    arr(1'b0, 1'b0, 1'b0);
    rd(`FCEF_OFS_ERRSTAT, 8'h01);
    irq_is(1'b1);
    arr(1'b1, 1'b0, 1'b1);
    clr();
    wr(`FCEF_OFS_CFG, 8'h00);
    arr(1'b0, 1'b1, 1'b1);
    arr(1'b0, 1'b0, 1'b0);
    rd(`FCEF_OFS_ERRSTAT, 8'h02);
    clr();
    arr(1'b1, 1'b0, 1'b1);
    rd(`FCEF_OFS_ERRSTAT, 8'h01);
    clr();
    $display("test fault inject done");
    wr(`FCEF_OFS_CFG, 8'h80);
    irq_is(1'b1);
    wr(`FCEF_OFS_STAT, 8'h80);
    #1;
    `CHK("cmdLaunch", 1'b1, cmdLaunch)
    wr(`FCEF_OFS_STAT, 8'h80);
    #1;
    `CHK("cmdLaunch", 1'b0, cmdLaunch)
    rd(`FCEF_OFS_STAT, 8'h00);
    irq_is(1'b0);
    repeat (DLY + 2) @(posedge ref_clk);
    rd(`FCEF_OFS_STAT, 8'h80);
    irq_is(1'b1);
    $display("test command done");
    wr(`FCEF_OFS_CFG, 8'h93);
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    rd(`FCEF_OFS_CFG, 8'h00);
    `CHK("wordSel", 3'h0, wordSel)
    $display("test second reset done");
    report_and_stop();
  end

  // About 160 cycles expected; hang guard well beyond
  initial begin
    repeat (3000) @(posedge ref_clk);
    nFail++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule // test_flash_cmd_index_and_ecc_fault_config
`default_nettype wire
